// ### rtl/gcsid_top.sv
`timescale 1ns/100ps
module gcsid_top (
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire gcsid_pkg::gcsid_io_t   io,
    input  wire logic [1:0]             boot_mode_pins,
    input  wire logic                   boot_fetch_ignore,
    input  wire logic                   wdog_timeout,
    input  wire logic                   clk32k_tick,
    input  wire logic                   power_save_short_cs,
    input  wire logic [1:0]             spread_mode,
    output logic [7:0]                  rdata,
    output logic                        periodic_pend,
    output logic [1:0]                  periodic_prio,
    output gcsid_pkg::gcsid_clk_t       clk_ctl,
    output logic                        rtc_tick,
    output logic                        baud_tick,
    output logic                        spread_stretch,
    output logic                        spread_shrink,
    output logic [2:0]                  spread_cycles
);
    import gcsid_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0]  cause_r;
    logic [2:0]  csel_r;
    logic [1:0]  prio_r;
    logic [1:0]  pins_r;
    logic        ign_r;
    logic [3:0]  cpu_ratio;
    logic [3:0]  per_ratio;
    logic        slow;
    logic        cpu_src;
    logic        per_src;
    logic        cpu_tick;
    logic        per_tick;
    logic [14:0] rtc_cnt_r;
    logic [3:0]  spr_cnt_r;
    logic [7:0]  id_hi;
    logic        gcs_wr;
    logic [7:0]  id_word [4];

    assign gcs_wr = io.wr && io.addr == GCSID_ADDR_GCS;
    assign id_hi  = {ign_r, pins_r, 5'h00};

    // ------------------------------------------------------------
    // identification words: only the low field differs per register
    // ------------------------------------------------------------
    localparam logic [4:0] ID_CODE [4] = '{GCSID_FLASH_ID, GCSID_RAM_ID,
                                           GCSID_CPU_ID, GCSID_REV_ID};
    for (genvar g = 0; g < 4; g++) begin : g_id
        assign id_word[g] = id_hi | {3'h0, ID_CODE[g]};
    end

    // ------------------------------------------------------------
    // strap sampling
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pins_r <= 2'h0;
            ign_r  <= 1'b0;
        end else begin
            pins_r <= boot_mode_pins;
            ign_r  <= boot_fetch_ignore;
        end
    end

    // ------------------------------------------------------------
    // read data; id writes fall through untouched
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (io.rd) begin
            unique case (io.addr)
                GCSID_ADDR_GCS:   rdata <= {cause_r, 1'b0, csel_r, prio_r};
                GCSID_ADDR_FLASH: rdata <= id_word[0];
                GCSID_ADDR_RAM:   rdata <= id_word[1];
                GCSID_ADDR_CPU:   rdata <= id_word[2];
                GCSID_ADDR_REV:   rdata <= id_word[3];
                default:          rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // cause flags: a new event wins over the read clear
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cause_r <= GCSID_CAUSE_RESET;
        // a timeout beside a clearing read must not be lost
        end else if (wdog_timeout) begin
            cause_r <= GCSID_CAUSE_WDOG;
        end else if (io.rd && io.addr == GCSID_ADDR_GCS) begin
            cause_r <= GCSID_CAUSE_NONE;
        end
    end

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            csel_r        <= GCSID_CSEL_RESET;
            prio_r        <= 2'h0;
            periodic_pend <= 1'b0;
            periodic_prio <= 2'h0;
        end else begin
            periodic_pend <= gcs_wr && io.wdata[GCSID_BIT_FORCE];
            // priority leaves with the write, never a cycle behind the field
            if (gcs_wr) begin
                csel_r        <= io.wdata[4:2];
                prio_r        <= io.wdata[1:0];
                periodic_prio <= io.wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // clock select decode
    // ------------------------------------------------------------
    always_comb begin
        cpu_ratio = GCSID_DIV8;
        per_ratio = GCSID_DIV8;
        slow      = 1'b0;
        unique case (csel_r)
            GCSID_CSEL_D8:   begin cpu_ratio = GCSID_DIV8; per_ratio = GCSID_DIV8; end
            GCSID_CSEL_D8P1: begin cpu_ratio = GCSID_DIV8; per_ratio = GCSID_DIV1; end
            GCSID_CSEL_D1:   begin cpu_ratio = GCSID_DIV1; per_ratio = GCSID_DIV1; end
            GCSID_CSEL_D2:   begin cpu_ratio = GCSID_DIV2; per_ratio = GCSID_DIV2; end
            GCSID_CSEL_D4:   begin cpu_ratio = GCSID_DIV4; per_ratio = GCSID_DIV4; end
            GCSID_CSEL_D6:   begin cpu_ratio = GCSID_DIV6; per_ratio = GCSID_DIV6; end
            GCSID_CSEL_SLOW, GCSID_CSEL_SLEEP: begin
                cpu_ratio = GCSID_DIV1;
                per_ratio = GCSID_DIV1;
                slow      = 1'b1;
            end
        endcase
    end

    // slow codes run both dividers at ratio one off the 32 kHz enable
    assign cpu_src = slow ? clk32k_tick : 1'b1;
    assign per_src = cpu_src;

    gcsid_divider u_cpu_div (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .src_en  (cpu_src),
        .ratio   (cpu_ratio),
        .tick    (cpu_tick)
    );

    gcsid_divider u_per_div (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .src_en  (per_src),
        .ratio   (per_ratio),
        .tick    (per_tick)
    );

    gcsid_divider u_baud_div (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .src_en  (clk32k_tick),
        .ratio   ({1'b0, GCSID_BAUD_DIV}),
        .tick    (baud_tick)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_ctl <= '0;
        end else begin
            clk_ctl.cpu_en   <= cpu_tick;
            clk_ctl.per_en   <= per_tick;
            clk_ctl.osc_on   <= csel_r != GCSID_CSEL_SLEEP;
            // short chip select only for the divide-by-8, 8/1, 4 and 6 codes, not divide-by-2
            clk_ctl.short_cs <= power_save_short_cs &&
                (csel_r == GCSID_CSEL_D8 || csel_r == GCSID_CSEL_D8P1 ||
                 csel_r == GCSID_CSEL_D4 || csel_r == GCSID_CSEL_D6);
        end
    end

    // ------------------------------------------------------------
    // real-time clock second tick from the 32 kHz enable
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rtc_cnt_r <= 15'h0000;
            rtc_tick  <= 1'b0;
        // free running, so the first second after reset is a full one
        end else begin
            rtc_tick <= clk32k_tick && rtc_cnt_r == GCSID_RTC_WRAP;
            if (clk32k_tick) begin
                rtc_cnt_r <= rtc_cnt_r + 15'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // spreader: alternate shrink and stretch, bounded amount
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            spr_cnt_r      <= 4'h0;
            spread_stretch <= 1'b0;
            spread_shrink  <= 1'b0;
            spread_cycles  <= 3'h0;
        end else begin
            // plain alternation: only the bound matters to the clock generator
            spr_cnt_r      <= spr_cnt_r + 4'h1;
            spread_stretch <= spread_mode != GCSID_SPR_OFF && !spr_cnt_r[0];
            spread_shrink  <= spread_mode != GCSID_SPR_OFF && spr_cnt_r[0];
            unique case (spread_mode)
                GCSID_SPR_NORMAL: spread_cycles <= 3'(GCSID_SPR_NORM_CYC);
                GCSID_SPR_STRONG: spread_cycles <= 3'(GCSID_SPR_STR_CYC);
                default:          spread_cycles <= 3'h0;
            endcase
        end
    end
endmodule // gcsid_top

// ### rtl/gcsid_pkg.sv
package gcsid_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] GCSID_ADDR_GCS   = 8'h00;
    localparam logic [7:0] GCSID_ADDR_FLASH = 8'h2C;
    localparam logic [7:0] GCSID_ADDR_RAM   = 8'h2D;
    localparam logic [7:0] GCSID_ADDR_CPU   = 8'h2E;
    localparam logic [7:0] GCSID_ADDR_REV   = 8'h2F;
    // identifiers: arbitrary neutral values
    localparam logic [4:0] GCSID_FLASH_ID   = 5'h0A;
    localparam logic [4:0] GCSID_RAM_ID     = 5'h0B;
    localparam logic [4:0] GCSID_CPU_ID     = 5'h0C;
    localparam logic [4:0] GCSID_REV_ID     = 5'h0D;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int GCSID_BIT_FORCE = 5;
    localparam logic [1:0] GCSID_CAUSE_NONE  = 2'h0;
    localparam logic [1:0] GCSID_CAUSE_WDOG  = 2'h1;
    localparam logic [1:0] GCSID_CAUSE_RESET = 2'h3;
    localparam logic [2:0] GCSID_CSEL_RESET  = 3'h0;
    localparam logic [2:0] GCSID_CSEL_D8     = 3'h0;
    localparam logic [2:0] GCSID_CSEL_D8P1   = 3'h1;
    localparam logic [2:0] GCSID_CSEL_D1     = 3'h2;
    localparam logic [2:0] GCSID_CSEL_D2     = 3'h3;
    localparam logic [2:0] GCSID_CSEL_SLOW   = 3'h4;
    localparam logic [2:0] GCSID_CSEL_SLEEP  = 3'h5;
    localparam logic [2:0] GCSID_CSEL_D4     = 3'h6;
    localparam logic [2:0] GCSID_CSEL_D6     = 3'h7;
    // divide ratios
    localparam logic [3:0] GCSID_DIV1 = 4'h1;
    localparam logic [3:0] GCSID_DIV2 = 4'h2;
    localparam logic [3:0] GCSID_DIV4 = 4'h4;
    localparam logic [3:0] GCSID_DIV6 = 4'h6;
    localparam logic [3:0] GCSID_DIV8 = 4'h8;
    // ------------------------------------------------------------
    // spreader timing
    // ------------------------------------------------------------
    localparam real GCSID_CLK_NS      = 10.0;
    localparam real GCSID_SPR_NORM_NS = 3.0;
    localparam real GCSID_SPR_STR_NS  = 4.5;
    // longest time rounds down, at least one cycle
    localparam int  GCSID_SPR_NORM_CYC =
        (int'($floor(GCSID_SPR_NORM_NS / GCSID_CLK_NS)) < 1) ? 1 :
        int'($floor(GCSID_SPR_NORM_NS / GCSID_CLK_NS));
    localparam int  GCSID_SPR_STR_CYC =
        (int'($floor(GCSID_SPR_STR_NS / GCSID_CLK_NS)) < 1) ? 1 :
        int'($floor(GCSID_SPR_STR_NS / GCSID_CLK_NS));
    localparam logic [1:0] GCSID_SPR_OFF    = 2'h0;
    localparam logic [1:0] GCSID_SPR_NORMAL = 2'h1;
    localparam logic [1:0] GCSID_SPR_STRONG = 2'h2;
    localparam logic [2:0] GCSID_BAUD_DIV   = 3'h7;   // 32768/2400 approx 14 = 2*7
    localparam logic [14:0] GCSID_RTC_WRAP  = 15'h7FFF;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gcsid_io_t;

    typedef struct packed {
        logic       cpu_en;
        logic       per_en;
        logic       osc_on;
        logic       short_cs;
    } gcsid_clk_t;
endpackage

// ### rtl/gcsid_divider.sv
`timescale 1ns/100ps
module gcsid_divider (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       src_en,
    input  wire logic [3:0] ratio,
    output logic            tick
);
    import gcsid_pkg::*;
    logic [3:0] cnt_r;

    // one-cycle enable every ratio source ticks
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 4'h0;
            tick  <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (src_en) begin
                if (cnt_r + 4'h1 >= ratio) begin
                    cnt_r <= 4'h0;
                    tick  <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 4'h1;
                end
            end
        end
    end
endmodule // gcsid_divider

// ### tb/gcsid_core_model.sv
`timescale 1ns/100ps
// ----------------
// core side: one internal i/o cycle at a time
// ----------------
module gcsid_core_model
    import gcsid_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic [7:0]      rdata,
    output gcsid_pkg::gcsid_io_t io
);
    initial io = '{wr: 1'b0, rd: 1'b0, addr: 8'hA5, wdata: 8'h5A};

    // idle bus shows inverted values so a stale address never passes
    task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] dat);
        @(posedge sys_clk);
        #1;
        io = '{wr: w, rd: !w, addr: a, wdata: dat};
        @(posedge sys_clk);
        #1;
        io = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~dat};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        cyc(1'b0, a, 8'h00);
        @(posedge sys_clk);
        #1;
        dat = rdata;
    endtask
endmodule // gcsid_core_model

// ### tb/gcsid_top_chk.sv
`timescale 1ns/100ps
// ----------------
// register-side checks
// ----------------
module gcsid_top_chk
    import gcsid_pkg::*;
(
    input wire logic                 sys_clk,
    input wire logic                 arst_n,
    input wire gcsid_pkg::gcsid_io_t io,
    input wire logic [1:0]           boot_mode_pins,
    input wire logic                 boot_fetch_ignore,
    input wire logic                 wdog_timeout,
    input wire logic [7:0]           rdata,
    input wire logic                 periodic_pend,
    input wire logic [1:0]           periodic_prio,
    input wire gcsid_pkg::gcsid_clk_t clk_ctl
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence rd_gcs;
        io.rd && io.addr == GCSID_ADDR_GCS;
    endsequence
    sequence wr_gcs;
        io.wr && io.addr == GCSID_ADDR_GCS;
    endsequence
    sequence quiet;
        !io.rd && !io.wr && !wdog_timeout;
    endsequence

    force_pend_a: assert property (wr_gcs ##0 io.wdata[5] |=> periodic_pend)
        else $error("no pending flag after force write");
    pend_once_a: assert property (periodic_pend && !io.wr |=> !periodic_pend)
        else $error("pending flag longer than one cycle");
    prio_set_a: assert property (wr_gcs |=> periodic_prio == $past(io.wdata[1:0]))
        else $error("priority does not follow write");
    rd_bits_a: assert property (rd_gcs |=> !rdata[5] && rdata[7:6] != 2'h2)
        else $error("bad status read bits");
    rd_clear_a: assert property (rd_gcs ##1 quiet [*2] ##1 rd_gcs
        |=> rdata[7:6] == GCSID_CAUSE_NONE)
        else $error("cause not cleared by read");
    wdog_cause_a: assert property (wdog_timeout && !io.rd ##1 !io.rd ##1 rd_gcs
        |=> rdata[7:6] == GCSID_CAUSE_WDOG)
        else $error("watchdog cause missing");
    cpu_id_a: assert property (io.rd && io.addr == GCSID_ADDR_CPU |=> rdata ==
        {$past(boot_fetch_ignore), $past(boot_mode_pins), GCSID_CPU_ID})
        else $error("cpu id read wrong");
    osc_off_a: assert property (wr_gcs ##0 io.wdata[4:2] == GCSID_CSEL_SLEEP
        |-> ##[1:3] !clk_ctl.osc_on)
        else $error("oscillator not stopped");
    osc_on_a: assert property (wr_gcs ##0 io.wdata[4:2] != GCSID_CSEL_SLEEP
        |-> ##[1:3] clk_ctl.osc_on)
        else $error("oscillator not running");
endmodule // gcsid_top_chk

bind gcsid_top gcsid_top_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .io(io),
    .boot_mode_pins(boot_mode_pins), .boot_fetch_ignore(boot_fetch_ignore),
    .wdog_timeout(wdog_timeout), .rdata(rdata), .periodic_pend(periodic_pend),
    .periodic_prio(periodic_prio), .clk_ctl(clk_ctl));

// ### tb/gcsid_top_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
end
// ----------------
// bench top
// ----------------
module gcsid_top_tb;
    import gcsid_pkg::*;
    logic                  sys_clk = 1'b0;
    logic                  arst_n;
    logic [1:0]            boot_mode_pins;
    logic                  boot_fetch_ignore;
    logic                  wdog_timeout;
    logic                  clk32k_tick;
    logic [7:0]            rdata;
    logic                  periodic_pend;
    logic [1:0]            periodic_prio;
    logic                  baud_tick;
    logic                  power_save_short_cs;
    logic [1:0]            spread_mode;
    logic                  rtc_tick;
    logic                  spread_stretch;
    logic                  spread_shrink;
    logic [2:0]            spread_cycles;
    logic [16:0]           tick_seen;
    logic [7:0]            d;
    gcsid_io_t             io;
    gcsid_clk_t            clk_ctl;
    int                    error_cnt = 0;
    int                    checked = 0;

    always #5 sys_clk = ~sys_clk;
    // slow tick every second cycle keeps the baud span short
    always @(posedge sys_clk) clk32k_tick <= #1 !clk32k_tick;

    // bench's own count of slow ticks since the last reset release
    always @(posedge sys_clk) begin
        if (!arst_n)
            tick_seen <= 17'h00000;
        else if (clk32k_tick)
            tick_seen <= tick_seen + 17'h00001;
    end

    gcsid_core_model core (.sys_clk(sys_clk), .rdata(rdata), .io(io));

    gcsid_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .io(io),
        .boot_mode_pins(boot_mode_pins), .boot_fetch_ignore(boot_fetch_ignore),
        .wdog_timeout(wdog_timeout), .clk32k_tick(clk32k_tick),
        .power_save_short_cs(power_save_short_cs), .spread_mode(spread_mode),
        .rdata(rdata), .periodic_pend(periodic_pend), .periodic_prio(periodic_prio),
        .clk_ctl(clk_ctl), .rtc_tick(rtc_tick), .baud_tick(baud_tick),
        .spread_stretch(spread_stretch), .spread_shrink(spread_shrink),
        .spread_cycles(spread_cycles));

    task automatic summarize;
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic t_reset_cause;
        core.rd(GCSID_ADDR_GCS, d);
        `CHK("gcs after reset", 8'hC0, d)
        core.rd(GCSID_ADDR_GCS, d);
        `CHK("gcs cleared", 8'h00, d)
    endtask

    task automatic t_ids;
        logic [7:0] a;
        logic [4:0] id [4] = '{GCSID_FLASH_ID, GCSID_RAM_ID, GCSID_CPU_ID, GCSID_REV_ID};
        for (int i = 0; i < 4; i++) begin
            boot_mode_pins = i[1:0];
            boot_fetch_ignore = ~i[1];
            a = GCSID_ADDR_FLASH + 8'(i);
            core.cyc(1'b1, a, 8'hFF);
            core.rd(a, d);
            `CHK("id reg", {~i[1], i[1:0], id[i]}, d)
        end
    endtask

    // cause bits written as ones must stay read-only
    // enables per 24 cycles; slow codes see a 32 kHz tick every second cycle
    task automatic t_csel;
        logic [5:0] cpu_n [8] = '{6'h03, 6'h03, 6'h18, 6'h0C, 6'h0C, 6'h0C, 6'h06, 6'h04};
        logic [5:0] per_n [8] = '{6'h03, 6'h18, 6'h18, 6'h0C, 6'h0C, 6'h0C, 6'h06, 6'h04};
        logic [5:0] nc;
        logic [5:0] np;
        power_save_short_cs = 1'b1;
        for (int c = 0; c < 8; c++) begin
            core.cyc(1'b1, GCSID_ADDR_GCS, {2'b11, c[0], c[2:0], c[1:0]});
            `CHK("force pend", c[0], periodic_pend)
            `CHK("prio", c[1:0], periodic_prio)
            core.rd(GCSID_ADDR_GCS, d);
            `CHK("gcs readback", {3'b000, c[2:0], c[1:0]}, d)
            `CHK("osc on", c != 5, clk_ctl.osc_on)
            `CHK("short cs", c < 2 || c > 5, clk_ctl.short_cs)
            nc = 6'h00;
            np = 6'h00;
            repeat (24) begin
                @(posedge sys_clk);
                #1;
                nc += clk_ctl.cpu_en;
                np += clk_ctl.per_en;
            end
            `CHK("cpu enables", cpu_n[c], nc)
            `CHK("per enables", per_n[c], np)
        end
    endtask

    task automatic t_wdog;
        core.rd(8'h10, d);
        `CHK("unmapped", 8'h00, d)
        @(posedge sys_clk);
        #1;
        wdog_timeout = 1'b1;
        @(posedge sys_clk);
        #1;
        wdog_timeout = 1'b0;
        core.rd(GCSID_ADDR_GCS, d);
        `CHK("wdog cause", 8'h5F, d)
        power_save_short_cs = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("normal cs", 1'b0, clk_ctl.short_cs)
    endtask

    // both spread modes bound the shortening to one cycle at this clock
    task automatic t_spread;
        logic       s0;
        logic [1:0] m [3] = '{GCSID_SPR_NORMAL, GCSID_SPR_STRONG, GCSID_SPR_OFF};
        logic [2:0] cy [3] = '{3'h1, 3'h1, 3'h0};
        for (int k = 0; k < 3; k++) begin
            spread_mode = m[k];
            repeat (2) @(posedge sys_clk);
            #1;
            s0 = spread_stretch;
            `CHK("spread cycles", cy[k], spread_cycles)
            `CHK("spread pair", k < 2, spread_stretch ^ spread_shrink)
            @(posedge sys_clk);
            #1;
            `CHK("spread turn", k < 2 && !s0, spread_stretch)
        end
    endtask

    // mid-run reset restarts the seconds count and reports reset as the cause
    task automatic t_rtc;
        @(posedge sys_clk);
        #1;
        arst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        for (int n = 0; n < 70000 && rtc_tick !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (rtc_tick !== 1'b1) begin
            error_cnt++;
            summarize();
        end
        `CHK("rtc span", 17'h08000, tick_seen)
        core.rd(GCSID_ADDR_GCS, d);
        `CHK("cause after reset", 8'hC0, d)
    endtask

    task automatic wait_baud(output int n);
        for (n = 1; n <= 40; n++) begin
            @(posedge sys_clk);
            #1;
            if (baud_tick === 1'b1)
                return;
        end
        error_cnt++;
        summarize();
    endtask

    task automatic t_baud;
        int n;
        wait_baud(n);
        wait_baud(n);
        `CHK("baud span", 14, n)
    endtask

    initial begin
        arst_n = 1'b0;
        boot_mode_pins = 2'h0;
        boot_fetch_ignore = 1'b0;
        wdog_timeout = 1'b0;
        clk32k_tick = 1'b0;
        power_save_short_cs = 1'b0;
        spread_mode = GCSID_SPR_OFF;
        repeat (20) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        t_reset_cause();
        t_ids();
        t_csel();
        t_wdog();
        t_baud();
        t_spread();
        t_rtc();
        summarize();
    end
endmodule // gcsid_top_tb
